// *** phyirq_pkg.sv ***
// Summary of operation
// - pending bit clears after basic-status then status read
// - power-up bit shows stable clocks, resets 0
// - transmit test sends regardless of link
// - repeater bit selects repeater/DTE, strap default
// - management-line irq needs global enable too
// - loopback control 0 loops, 1 disables
// - SQE generated only when bit set
// - jabber protection active unless bit set
// - link-test bit skips link integrity test
// - link-test reset: 0 with autoneg, else strap
// - LED field: collision, off, activity, on
// - clock-advance bit shifts transmit clock earlier
// - symbol bit bypasses encoder, strap default
// - scrambler bypass bit, strap default
// - fiber mode always bypasses the scrambler
// - fiber plus bypass also forces symbol mode
// - media bit selects fiber; autoneg or strap reset
// - transmit-disconnect bit cuts twisted-pair transmitter
// - global enable gates test and line interrupts
package phyirq_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CORE_CLK_NS = 40;
	localparam int IRQ_PULSE_NS = 320;
	localparam int IRQ_PULSE_CYC_INT = (IRQ_PULSE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam logic [3:0] IRQ_PULSE_CYC = 4'(IRQ_PULSE_CYC_INT);
	localparam logic [1:0] STRAP_LOAD_CYC = 2'h2;

	// ---------------------------------------------------------------
	// management frame
	// ---------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [3:0] HEADER_LAST = 4'hB;
	localparam logic [3:0] DATA_LAST = 4'hF;
	localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h12;
	localparam logic [4:0] REG_CONFIG = 5'h13;

	// ---------------------------------------------------------------
	// register fields and resets
	// ---------------------------------------------------------------
	localparam int ISR_PENDING_BIT = 15;
	localparam int ISR_POWERED_BIT = 14;
	localparam logic [15:0] ISR_RESET = 16'h0000;
	localparam int CFG_TX_TEST_BIT = 14;
	localparam int CFG_REPEATER_BIT = 13;
	localparam int CFG_MDIO_IRQ_BIT = 12;
	localparam int CFG_LOOP_DIS_BIT = 11;
	localparam int CFG_SQE_BIT = 10;
	localparam int CFG_JABBER_DIS_BIT = 9;
	localparam int CFG_LINK_TEST_DIS_BIT = 8;
	localparam int CFG_LED_HI_BIT = 7;
	localparam int CFG_LED_LO_BIT = 6;
	localparam int CFG_TX_ADV_BIT = 5;
	localparam int CFG_SYMBOL_BIT = 4;
	localparam int CFG_SCR_BYP_BIT = 3;
	localparam int CFG_FIBER_BIT = 2;
	localparam int CFG_TX_DISC_BIT = 0;
	localparam logic [15:0] CFG_WRITE_MASK = 16'h7FFD;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	localparam logic [1:0] LED_COLLISION = 2'h0;
	localparam logic [1:0] LED_OFF = 2'h1;
	localparam logic [1:0] LED_ACTIVITY = 2'h2;
	localparam logic [1:0] LED_ON = 2'h3;

	typedef enum logic [2:0] {
		FR_IDLE,
		FR_START,
		FR_HEADER,
		FR_TURN,
		FR_DATA
	} phyirq_frame_type;

endpackage : phyirq_pkg

// *** phyirq_sync.sv ***
`timescale 1ns/10ps
module phyirq_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : phyirq_sync

// *** phyirq_edge.sv ***
`timescale 1ns/10ps
module phyirq_edge (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic level_in,
	output logic rise_pulse
);
	logic prev_q;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			prev_q <= 1'b0;
		else
			prev_q <= level_in;
	end

	assign rise_pulse = level_in & ~prev_q;
endmodule : phyirq_edge

// *** phyirq_regs.sv ***
`timescale 1ns/10ps
module phyirq_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic clocks_stable,
	input wire logic strap_pin_one,
	input wire logic strap_pin_two,
	input wire logic strap_pin_three,
	input wire logic strap_pin_four,
	input wire logic config_strap_pin,
	input wire logic autoneg_strap,
	input wire logic global_irq_enable,
	input wire logic test_irq_force,
	input wire logic irq_event,
	input wire logic link_up,
	input wire logic collision_seen,
	input wire logic activity_seen,
	output logic mgmt_irq_pending,
	output logic powered_up,
	output logic tx_allowed,
	output logic repeater_mode,
	output logic loopback_disable,
	output logic sqe_enable,
	output logic jabber_disable,
	output logic link_test_disable,
	output logic third_led_output,
	output logic tx_clk_advance,
	output logic symbol_mode,
	output logic scrambler_bypass,
	output logic fiber_select,
	output logic tx_disconnect
);
	import phyirq_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [8:0] pins_s;
	logic mdc_s;
	logic mdio_s;
	logic stable_s;
	logic mdc_rise;

	phyirq_sync #(
		.W(9)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({mdc, mdio_in, clocks_stable, strap_pin_one, strap_pin_two,
			strap_pin_three, strap_pin_four, config_strap_pin, autoneg_strap}),
		.sync_out(pins_s)
	);

	assign mdc_s = pins_s[8];
	assign mdio_s = pins_s[7];
	assign stable_s = pins_s[6];

	// the 320 ns management clock gives eight core samples per bit
	phyirq_edge u_edge (
		.core_clk(core_clk),
		.reset(reset),
		.level_in(mdc_s),
		.rise_pulse(mdc_rise)
	);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		phyirq_frame_type st;
		logic [5:0] ones;
		logic [3:0] bit_cnt;
		logic [11:0] hdr;
		logic drive;
		logic wr_cfg;
		logic [15:0] shift;
		logic status_seen;
		logic pending;
		logic pend_prev;
		logic [3:0] irq_cnt;
		logic [15:0] cfg;
		logic strap_done;
		logic [1:0] strap_cnt;
		logic mdio_out;
		logic mdio_oe;
		logic powered;
		logic tx_ok;
		logic led;
		logic scr_byp;
		logic sym_mode;
	} phyirq_state_type;

	phyirq_state_type q;
	phyirq_state_type d;

	always_comb
	begin
		logic [11:0] h;
		logic [15:0] w;
		logic clr;
		logic set;
		logic ours;
		h = '0;
		w = '0;
		clr = 1'b0;
		set = 1'b0;
		ours = 1'b0;
		d = q;

		// -----------------------------------------------------------
		// strap capture after reset release
		// -----------------------------------------------------------
		if (!q.strap_done)
		begin
			d.strap_cnt = q.strap_cnt + 2'h1;
			if (q.strap_cnt == STRAP_LOAD_CYC)
			begin
				d.strap_done = 1'b1;
				d.cfg[CFG_REPEATER_BIT] = pins_s[5];
				d.cfg[CFG_SYMBOL_BIT] = pins_s[4];
				d.cfg[CFG_SCR_BYP_BIT] = pins_s[3];
				d.cfg[CFG_FIBER_BIT] = pins_s[2] & ~pins_s[0];
				d.cfg[CFG_LINK_TEST_DIS_BIT] = pins_s[1] & ~pins_s[0];
			end
		end

		// -----------------------------------------------------------
		// management frame decode
		// -----------------------------------------------------------
		if (mdc_rise)
		begin
			case (q.st)
				FR_IDLE:
				begin
					if (mdio_s)
					begin
						if (q.ones != PREAMBLE_ONES)
							d.ones = q.ones + 6'h01;
					end
					else
					begin
						if (q.ones == PREAMBLE_ONES)
							d.st = FR_START;
						d.ones = '0;
					end
				end
				FR_START:
				begin
					d.bit_cnt = '0;
					d.st = mdio_s ? FR_HEADER : FR_IDLE;
				end
				FR_HEADER:
				begin
					h = {q.hdr[10:0], mdio_s};
					d.hdr = h;
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == HEADER_LAST)
					begin
						ours = (h[9:5] == PHY_ADDR);
						d.bit_cnt = '0;
						d.drive = 1'b0;
						d.wr_cfg = 1'b0;
						d.st = FR_TURN;
						if (h[11:10] == OP_READ)
						begin
							if (ours && h[4:0] == REG_BASIC_STATUS)
								d.status_seen = 1'b1;
							if (ours && h[4:0] == REG_IRQ_STATUS)
							begin
								d.drive = 1'b1;
								d.shift = ISR_RESET;
								d.shift[ISR_PENDING_BIT] = q.pending;
								d.shift[ISR_POWERED_BIT] = q.powered;
								if (q.status_seen)
								begin
									clr = 1'b1;
									d.status_seen = 1'b0;
								end
							end
							if (ours && h[4:0] == REG_CONFIG)
							begin
								d.drive = 1'b1;
								d.shift = q.cfg;
							end
						end
						else if (h[11:10] == OP_WRITE)
							d.wr_cfg = ours && h[4:0] == REG_CONFIG;
						else
							d.st = FR_IDLE;
					end
				end
				FR_TURN:
				begin
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == 4'h0)
					begin
						d.mdio_oe = q.drive;
						d.mdio_out = 1'b0;
					end
					else
					begin
						d.mdio_out = q.drive & q.shift[15];
						d.shift = {q.shift[14:0], 1'b0};
						d.bit_cnt = '0;
						d.st = FR_DATA;
					end
				end
				FR_DATA:
				begin
					w = {q.shift[14:0], mdio_s};
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.drive)
					begin
						d.mdio_out = q.shift[15];
						d.shift = {q.shift[14:0], 1'b0};
					end
					else
						d.shift = w;
					if (q.bit_cnt == DATA_LAST)
					begin
						d.mdio_oe = 1'b0;
						d.mdio_out = 1'b0;
						d.st = FR_IDLE;
						d.ones = '0;
						if (q.wr_cfg)
							d.cfg = w & CFG_WRITE_MASK;
					end
				end
				default:
				begin
					d.st = FR_IDLE;
				end
			endcase
		end

		// -----------------------------------------------------------
		// pending interrupt and line signalling
		// -----------------------------------------------------------
		// gated test force
		set = irq_event | (global_irq_enable & test_irq_force);
		d.pending = (q.pending & ~clr) | set;
		d.pend_prev = q.pending;

		// the pulse corrupts any frame the master starts meanwhile
		if (q.irq_cnt != 4'h0)
		begin
			d.irq_cnt = q.irq_cnt - 4'h1;
			if (q.irq_cnt == 4'h1)
				d.mdio_oe = 1'b0;
		end
		else if (q.st == FR_IDLE && !q.mdio_oe && q.pending && !q.pend_prev
			&& q.cfg[CFG_MDIO_IRQ_BIT] && global_irq_enable)
		begin
			d.irq_cnt = IRQ_PULSE_CYC;
			d.mdio_oe = 1'b1;
			d.mdio_out = 1'b0;
		end

		// -----------------------------------------------------------
		// derived controls
		// -----------------------------------------------------------
		// clocks stable flag
		d.powered = stable_s;
		d.tx_ok = link_up | q.cfg[CFG_TX_TEST_BIT];
		case (q.cfg[CFG_LED_HI_BIT:CFG_LED_LO_BIT])
			LED_COLLISION: d.led = collision_seen;
			LED_OFF: d.led = 1'b0;
			LED_ACTIVITY: d.led = activity_seen;
			LED_ON: d.led = 1'b1;
			default: d.led = 1'b0;
		endcase
		d.scr_byp = q.cfg[CFG_SCR_BYP_BIT] | q.cfg[CFG_FIBER_BIT];
		d.sym_mode = q.cfg[CFG_SYMBOL_BIT]
			| (q.cfg[CFG_FIBER_BIT] & q.cfg[CFG_SCR_BYP_BIT]);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			q <= '0;
			q.st <= FR_IDLE;
			q.cfg <= CFG_RESET;
		end
		else
			q <= d;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign mdio_out = q.mdio_out;
	assign mdio_oe = q.mdio_oe;
	assign mgmt_irq_pending = q.pending;
	assign powered_up = q.powered;
	assign tx_allowed = q.tx_ok;
	assign repeater_mode = q.cfg[CFG_REPEATER_BIT];
	assign loopback_disable = q.cfg[CFG_LOOP_DIS_BIT];
	assign sqe_enable = q.cfg[CFG_SQE_BIT];
	assign jabber_disable = q.cfg[CFG_JABBER_DIS_BIT];
	assign link_test_disable = q.cfg[CFG_LINK_TEST_DIS_BIT];
	assign third_led_output = q.led;
	assign tx_clk_advance = q.cfg[CFG_TX_ADV_BIT];
	assign symbol_mode = q.sym_mode;
	assign scrambler_bypass = q.scr_byp;
	assign fiber_select = q.cfg[CFG_FIBER_BIT];
	assign tx_disconnect = q.cfg[CFG_TX_DISC_BIT];
endmodule : phyirq_regs

// *** phyirq_regs_chk.sv ***
`timescale 1ns/10ps
module phyirq_regs_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic clocks_stable,
	input wire logic global_irq_enable,
	input wire logic test_irq_force,
	input wire logic irq_event,
	input wire logic link_up,
	input wire logic mgmt_irq_pending,
	input wire logic powered_up,
	input wire logic tx_allowed,
	input wire logic repeater_mode,
	input wire logic loopback_disable,
	input wire logic sqe_enable,
	input wire logic jabber_disable,
	input wire logic link_test_disable,
	input wire logic tx_clk_advance,
	input wire logic scrambler_bypass,
	input wire logic fiber_select,
	input wire logic tx_disconnect
);
	// ----------------------------
	// management line quiet time
	// ----------------------------
	logic [3:0] quiet_q;
	logic mdc_q;
	// a frame can only change state a few cycles after an mdc edge
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
		begin
			quiet_q <= 4'h0;
			mdc_q <= 1'b0;
		end
		else
		begin
			mdc_q <= mdc;
			quiet_q <= (mdc != mdc_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
		end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence clk_held;
		clocks_stable [*5];
	endsequence
	sequence clk_lost;
		!clocks_stable [*5];
	endsequence
	sequence line_quiet;
		(!mdio_oe) [*8];
	endsequence
	a_power_up: assert property (clk_held |=> powered_up)
		else $error("powered flag missing");
	a_power_down: assert property (clk_lost |=> !powered_up)
		else $error("powered flag without stable clocks");
	a_pend_event: assert property (irq_event |=> mgmt_irq_pending)
		else $error("event did not set pending");
	a_pend_force: assert property (global_irq_enable && test_irq_force
		|=> mgmt_irq_pending)
		else $error("test force did not set pending");
	a_pend_hold: assert property (mgmt_irq_pending && quiet_q > 4'h8
		|=> mgmt_irq_pending)
		else $error("pending cleared without a read");
	a_fiber_scr: assert property (fiber_select |=> scrambler_bypass)
		else $error("fiber without scrambler bypass");
	a_tx_link: assert property (link_up |=> tx_allowed)
		else $error("link up but transmit gated");
	a_irq_gated: assert property ($rose(mgmt_irq_pending) && !global_irq_enable
		|-> ##2 line_quiet)
		else $error("line interrupt without global enable");
	a_cfg_quiet: assert property (quiet_q > 4'h8 |-> $stable({repeater_mode,
		loopback_disable, sqe_enable, jabber_disable, link_test_disable, tx_clk_advance,
		fiber_select, tx_disconnect}))
		else $error("control changed without a frame");
endmodule : phyirq_regs_chk
bind phyirq_regs phyirq_regs_chk u_phyirq_regs_chk (.core_clk, .reset, .mdc, .mdio_out,
	.mdio_oe, .clocks_stable, .global_irq_enable, .test_irq_force, .irq_event, .link_up,
	.mgmt_irq_pending, .powered_up, .tx_allowed, .repeater_mode, .loopback_disable,
	.sqe_enable, .jabber_disable, .link_test_disable, .tx_clk_advance, .scrambler_bypass,
	.fiber_select, .tx_disconnect);

// *** phyirq_mac_model.sv ***
`timescale 1ns/10ps
module phyirq_mac_model (
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe
);
	logic drv;
	logic val;
	// line has a pull-up, so a released line reads high
	assign mdio_in = mdio_oe ? mdio_out : (drv ? val : 1'b1);
	initial
	begin
		mdc = 1'b0;
		drv = 1'b0;
		val = 1'b1;
	end
	// mdc runs only inside a frame; data changes after the falling edge
	task xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFF_FFFF, 2'b01, op, 5'h00, ra, 2'b10, wd & 16'h7FFD};
		#7;
		for (int i = 0; i < 64; i++)
		begin
			drv = (op == 2'h1) || (i < 46);
			val = bits[63 - i];
			#160 mdc = 1'b1;
			if (i >= 48)
				rd[63 - i] = mdio_in;
			#160 mdc = 1'b0;
		end
		drv = 1'b0;
		#640;
	endtask : xfer
endmodule : phyirq_mac_model

// *** tb_phyirq_regs.sv ***
`timescale 1ns/10ps
module tb_phyirq_regs;
	import phyirq_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clocks_stable = 1'b0;
	logic strap_pin_one = 1'b1, strap_pin_two = 1'b0, strap_pin_three = 1'b1;
	logic strap_pin_four = 1'b1, config_strap_pin = 1'b1, autoneg_strap = 1'b0;
	logic global_irq_enable = 1'b0, test_irq_force = 1'b0, irq_event = 1'b0;
	logic link_up = 1'b0, collision_seen = 1'b0, activity_seen = 1'b0;
	logic mdc, mdio_in, mdio_out, mdio_oe, mgmt_irq_pending, powered_up, tx_allowed;
	logic repeater_mode, loopback_disable, sqe_enable, jabber_disable, link_test_disable;
	logic third_led_output, tx_clk_advance, symbol_mode, scrambler_bypass, fiber_select;
	logic tx_disconnect;
	logic [15:0] rd;
	int failures = 0;
	int check_count = 0;
	always #20 core_clk = ~core_clk;
	phyirq_regs u_phyirq_regs (.core_clk, .reset, .mdc, .mdio_in, .mdio_out, .mdio_oe,
		.clocks_stable, .strap_pin_one, .strap_pin_two, .strap_pin_three, .strap_pin_four,
		.config_strap_pin, .autoneg_strap, .global_irq_enable, .test_irq_force, .irq_event,
		.link_up, .collision_seen, .activity_seen, .mgmt_irq_pending, .powered_up,
		.tx_allowed, .repeater_mode, .loopback_disable, .sqe_enable, .jabber_disable,
		.link_test_disable, .third_led_output, .tx_clk_advance, .symbol_mode,
		.scrambler_bypass, .fiber_select, .tx_disconnect);
	phyirq_mac_model u_phyirq_mac_model (.mdc, .mdio_in, .mdio_out, .mdio_oe);
	// ----------------------------
	// shared tasks
	// ----------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task rw(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
		u_phyirq_mac_model.xfer(op, ra, wd, rd);
		@(negedge core_clk);
	endtask : rw
	task t_straps;
		rw(OP_READ, REG_CONFIG, 16'h0);
		chk(rd, 16'h210C);
		chk(16'({repeater_mode, link_test_disable, symbol_mode,
			scrambler_bypass, fiber_select}), 16'h1F);
		chk(16'(powered_up), 16'h1);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'h4000);
		$display("straps done");
	endtask : t_straps
	task t_cfg;
		logic [3:0] t;
		for (int k = 0; k < 2; k++)
		begin
			rw(OP_WRITE, REG_CONFIG, k ? 16'h0 : 16'hFFFF);
			rw(OP_READ, REG_CONFIG, 16'h0);
			chk(rd, k ? 16'h0 : 16'h7FFD);
			chk(16'({tx_allowed, repeater_mode, loopback_disable, sqe_enable, jabber_disable,
				link_test_disable, tx_clk_advance, tx_disconnect, symbol_mode, scrambler_bypass,
				fiber_select}), k ? 16'h0 : 16'h7FF);
		end
		link_up = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(16'(tx_allowed), 16'h1);
		link_up = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			collision_seen = k[2];
			activity_seen = ~k[2];
			rw(OP_WRITE, REG_CONFIG, {8'h0, k[1:0], 6'h0});
			t = {1'b1, ~k[2], 1'b0, k[2]};
			chk(16'(third_led_output), 16'(t[k[1:0]]));
		end
		$display("config done");
	endtask : t_cfg
	task t_irq;
		int n;
		rw(OP_WRITE, REG_IRQ_STATUS, 16'hFFFF);
		// line signalling armed, so only the global enable keeps the line quiet
		rw(OP_WRITE, REG_CONFIG, 16'h1000);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'h4000);
		irq_event = 1'b1;
		@(negedge core_clk);
		irq_event = 1'b0;
		n = 0;
		repeat (12)
		begin
			@(negedge core_clk);
			n += int'(mdio_oe !== 1'b0);
		end
		chk(16'(n), 16'h0);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'hC000);
		rw(OP_READ, REG_BASIC_STATUS, 16'h0);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'hC000);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'h4000);
		$display("interrupt done");
	endtask : t_irq
	task t_line;
		int n;
		rw(OP_WRITE, REG_CONFIG, 16'h1000);
		test_irq_force = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(16'(mgmt_irq_pending), 16'h0);
		global_irq_enable = 1'b1;
		n = 0;
		repeat (14)
		begin
			@(negedge core_clk);
			n += int'(mdio_oe === 1'b1 && mdio_out === 1'b0);
		end
		chk(16'(n), 16'h8);
		test_irq_force = 1'b0;
		global_irq_enable = 1'b0;
		rw(OP_READ, REG_BASIC_STATUS, 16'h0);
		rw(OP_READ, REG_IRQ_STATUS, 16'h0);
		chk(rd, 16'hC000);
		$display("line interrupt done");
	endtask : t_line
	task t_autoneg;
		reset = 1'b1;
		autoneg_strap = 1'b1;
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		repeat (10) @(negedge core_clk);
		rw(OP_READ, REG_CONFIG, 16'h0);
		chk(rd, 16'h2008);
		chk(16'({link_test_disable, fiber_select, symbol_mode, scrambler_bypass}), 16'h1);
		$display("autoneg straps done");
	endtask : t_autoneg
	task final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		repeat (10) @(negedge core_clk);
		clocks_stable = 1'b1;
		t_straps();
		t_cfg();
		t_irq();
		t_line();
		t_autoneg();
		final_report();
	end
	// about 25 frames of 530 cycles each fit well inside this span
	initial
	begin
		#2000000;
		failures++;
		final_report();
	end
endmodule : tb_phyirq_regs
